// ===== rtl/iacl_pkg.sv
// Purpose: Shared types and constants for the IPv4 entry field matcher.
// Assumes: Header fields are already extracted by the port pipeline.
// Notes:   Mode encodings are enums; configuration travels as a struct.
package iacl_pkg;

  localparam int unsigned ADDR_W      = 32;
  localparam int unsigned PROTO_W     = 8;
  localparam int unsigned TTL_W       = 8;
  localparam int unsigned FRAG_OFF_W  = 13;
  localparam int unsigned IHL_W       = 4;

  localparam logic [PROTO_W-1:0]    PROTO_ICMP    = 8'h01;
  localparam logic [PROTO_W-1:0]    PROTO_TCP     = 8'h06;
  localparam logic [PROTO_W-1:0]    PROTO_UDP     = 8'h11;
  localparam logic [TTL_W-1:0]      TTL_ZERO      = 8'h00;
  localparam logic [FRAG_OFF_W-1:0] FRAG_OFF_ZERO = 13'h0000;
  localparam logic [IHL_W-1:0]      IHL_NO_OPT    = 4'h5;

  typedef enum logic [1:0] {
    IACL_FT_ANY,
    IACL_FT_ETH,
    IACL_FT_ARP,
    IACL_FT_IPV4
  } iacl_ftype_e;

  typedef enum logic [2:0] {
    IACL_PR_ANY,
    IACL_PR_SPECIFIC,
    IACL_PR_ICMP,
    IACL_PR_UDP,
    IACL_PR_TCP
  } iacl_proto_e;

  // Shared by TTL, fragment and option settings: zero/no, nonzero/yes, any.
  typedef enum logic [1:0] {
    IACL_TRI_ANY,
    IACL_TRI_NO,
    IACL_TRI_YES
  } iacl_tri_e;

  typedef enum logic [1:0] {
    IACL_IP_ANY,
    IACL_IP_HOST,
    IACL_IP_NETWORK
  } iacl_ipflt_e;

  typedef struct packed {
    iacl_ftype_e              frame_type;
    iacl_proto_e              proto_mode;
    logic [PROTO_W-1:0]       proto_value;
    iacl_tri_e                ttl_mode;
    iacl_tri_e                frag_mode;
    iacl_tri_e                opt_mode;
    iacl_ipflt_e              source_ip_filter;
    logic [ADDR_W-1:0]        src_addr;
    logic [ADDR_W-1:0]        src_mask;
    iacl_ipflt_e              dest_ip_filter;
    logic [ADDR_W-1:0]        dst_addr;
    logic [ADDR_W-1:0]        dst_mask;
  } iacl_cfg_s;

  typedef struct packed {
    logic                     is_ipv4;
    logic [PROTO_W-1:0]       proto;
    logic [TTL_W-1:0]         ttl;
    logic                     more_fragments_flag;
    logic [FRAG_OFF_W-1:0]    fragment_offset_field;
    logic [IHL_W-1:0]         ihl;
    logic [ADDR_W-1:0]        src_addr;
    logic [ADDR_W-1:0]        dst_addr;
  } iacl_hdr_s;

endpackage

// ===== rtl/iacl_matcher.sv
// Purpose: Decide whether one IPv4 frame hits one access_control_entry.
// Assumes: Header struct and l4_extra_ok come from the same clock domain.
// Notes:   One cycle of latency from hdr_valid to hit_valid.
// Notes on behaviour
// - Only an entry whose frame type is IPv4 can hit; any other frame type never hits.
// - Protocol filter any ignores the protocol field.
// - Specific protocol matches an 8-bit configured value exactly.
// - ICMP shortcut needs ICMP and the extra ICMP criteria.
// - UDP shortcut needs UDP and the extra UDP criteria.
// - TCP shortcut needs TCP and the extra TCP criteria.
// - TTL setting zero excludes frames with nonzero TTL.
// - TTL setting nonzero admits nonzero TTL; any ignores TTL.
// - Fragment setting no excludes frames with flag set or offset nonzero.
// - Fragment setting yes admits fragments; any ignores fragmentation.
// - Option setting no excludes frames whose header carries options.
// - Option setting yes admits frames with options; any ignores them.
// - Source filter any ignores the source address.
// - Source filter host needs source equal to configured address.
// - Source filter network compares source under the source mask.
// - Destination filter any ignores the destination address.
// - Destination filter host needs exact destination address equality.
// - Destination filter network compares under the destination mask.
`timescale 1ns/1ps

module iacl_matcher
  import iacl_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  input  wire iacl_pkg::iacl_cfg_s  cfg,
  input  wire logic                 hdr_valid,
  input  wire iacl_pkg::iacl_hdr_s  hdr,
  input  wire logic                 l4_extra_ok,
  output logic                      hit_valid,
  output logic                      hit,
  output logic                      ipv4_sel
);
  import iacl_pkg::*;

  // ----------------------------------------------------------------------
  // Address comparison
  // ----------------------------------------------------------------------
  function automatic logic addr_ok(input iacl_ipflt_e      mode,
                                   input logic [ADDR_W-1:0] frame_a,
                                   input logic [ADDR_W-1:0] cfg_a,
                                   input logic [ADDR_W-1:0] mask);
    logic r;
    r = 1'b1;
    case (mode)
      IACL_IP_ANY:     r = 1'b1;
      IACL_IP_HOST:    r = (frame_a == cfg_a);
      IACL_IP_NETWORK: r = ((frame_a & mask) == (cfg_a & mask));
      // Unused encoding never hits, so a corrupted setting fails safe.
      default:         r = 1'b0;
    endcase
    return r;
  endfunction

  // A tri-state setting: no requires the property absent, yes present.
  function automatic logic tri_ok(input iacl_tri_e mode,
                                  input logic      present);
    logic r;
    r = 1'b1;
    case (mode)
      IACL_TRI_ANY: r = 1'b1;
      IACL_TRI_NO:  r = ~present;
      IACL_TRI_YES: r = present;
      default:      r = 1'b0;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Criteria evaluation
  // ----------------------------------------------------------------------
  logic proto_ok;
  logic ttl_ok;
  logic frag_ok;
  logic opt_ok;
  logic src_ok;
  logic dst_ok;
  logic ip_sel;
  logic match_now;
  logic is_frag;
  logic has_opt;
  logic ttl_nz;

  always_comb begin
    ip_sel  = (cfg.frame_type == IACL_FT_IPV4);
    ttl_nz  = (hdr.ttl != TTL_ZERO);
    is_frag = hdr.more_fragments_flag |
              (hdr.fragment_offset_field != FRAG_OFF_ZERO);
    // A header longer than the minimum length carries options.
    has_opt = (hdr.ihl > IHL_NO_OPT);
    proto_ok = 1'b1;
    case (cfg.proto_mode)
      IACL_PR_ANY:      proto_ok = 1'b1;
      IACL_PR_SPECIFIC: proto_ok = (hdr.proto == cfg.proto_value);
      IACL_PR_ICMP:     proto_ok = (hdr.proto == PROTO_ICMP) &
                                   l4_extra_ok;
      IACL_PR_UDP:      proto_ok = (hdr.proto == PROTO_UDP) &
                                   l4_extra_ok;
      IACL_PR_TCP:      proto_ok = (hdr.proto == PROTO_TCP) &
                                   l4_extra_ok;
      default:          proto_ok = 1'b0;
    endcase
    ttl_ok  = tri_ok(cfg.ttl_mode, ttl_nz);
    frag_ok = tri_ok(cfg.frag_mode, is_frag);
    opt_ok  = tri_ok(cfg.opt_mode, has_opt);
    src_ok  = addr_ok(cfg.source_ip_filter, hdr.src_addr,
                      cfg.src_addr, cfg.src_mask);
    dst_ok  = addr_ok(cfg.dest_ip_filter, hdr.dst_addr,
                      cfg.dst_addr, cfg.dst_mask);
    // Non-IPv4 frames cannot hit an entry that selects IPv4.
    match_now = ip_sel & hdr.is_ipv4 & proto_ok & ttl_ok & frag_ok &
                opt_ok & src_ok & dst_ok;
  end

  // ----------------------------------------------------------------------
  // Result register
  // ----------------------------------------------------------------------
  logic hit_valid_r;
  logic hit_valid_nxt;
  logic hit_r;
  logic hit_nxt;

  always_comb begin
    hit_valid_nxt = hdr_valid;
    // Hold the last verdict between frames so consumers see a stable value.
    hit_nxt       = hdr_valid ? match_now : hit_r;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hit_valid_r <= 1'b0;
      hit_r       <= 1'b0;
    end else begin
      hit_valid_r <= hit_valid_nxt;
      hit_r       <= hit_nxt;
    end
  end

  assign hit_valid = hit_valid_r;
  assign hit       = hit_r;
  assign ipv4_sel  = ip_sel;

endmodule

// ===== sim/iacl_checker.sv
// Purpose: Port-level assertions for the entry field matcher.
// Assumes: The verdict lands one cycle after a taken header.
// Notes:   Each exclusion is tied to the header that caused it.
`timescale 1ns/1ps
module iacl_checker
  import iacl_pkg::*;
(
  input wire logic               sys_clk,
  input wire logic               resetn,
  input wire iacl_pkg::iacl_cfg_s cfg,
  input wire logic               hdr_valid,
  input wire iacl_pkg::iacl_hdr_s hdr,
  input wire logic               l4_extra_ok,
  input wire logic               hit_valid,
  input wire logic               hit,
  input wire logic               ipv4_sel
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  verdict_lat_a:
    assert property (hdr_valid |=> hit_valid) else $error("verdict late");
  verdict_hold_a:
    assert property (!hdr_valid |=> !hit_valid && $stable(hit))
      else $error("spurious verdict");
  type_sel_a:
    assert property (ipv4_sel == (cfg.frame_type == IACL_FT_IPV4))
      else $error("select wrong");
  type_excl_a:
    assert property (hdr_valid && !(ipv4_sel && hdr.is_ipv4) |=> !hit)
      else $error("non ipv4 hit");
  proto_spec_a:
    assert property (hdr_valid && cfg.proto_mode == IACL_PR_SPECIFIC &&
      hdr.proto != cfg.proto_value |=> !hit) else $error("proto hit");
  ttl_zero_a:
    assert property (hdr_valid && cfg.ttl_mode == IACL_TRI_NO &&
      hdr.ttl != TTL_ZERO |=> !hit) else $error("ttl hit");
  frag_no_a:
    assert property (hdr_valid && cfg.frag_mode == IACL_TRI_NO &&
      (hdr.more_fragments_flag || hdr.fragment_offset_field != FRAG_OFF_ZERO)
      |=> !hit) else $error("fragment hit");
  opt_no_a:
    assert property (hdr_valid && cfg.opt_mode == IACL_TRI_NO &&
      hdr.ihl > IHL_NO_OPT |=> !hit) else $error("option hit");
  src_host_a:
    assert property (hdr_valid && cfg.source_ip_filter == IACL_IP_HOST &&
      hdr.src_addr != cfg.src_addr |=> !hit) else $error("source hit");
  dst_net_a:
    assert property (hdr_valid && cfg.dest_ip_filter == IACL_IP_NETWORK &&
      ((hdr.dst_addr ^ cfg.dst_addr) & cfg.dst_mask) != '0 |=> !hit)
      else $error("dest hit");
  hit_c: cover property (hit_valid && hit);
  miss_c: cover property (hit_valid && !hit);
  b2b_c: cover property (hdr_valid ##1 hdr_valid);
endmodule
bind iacl_matcher iacl_checker u_iacl_checker (.sys_clk, .resetn, .cfg,
  .hdr_valid, .hdr, .l4_extra_ok, .hit_valid, .hit, .ipv4_sel);

// ===== sim/iacl_port_src.sv
// Purpose: Switch port pipeline that hands extracted headers on.
// Assumes: Called at a falling edge; gap 0 keeps the strobe up.
// Notes:   Idle fields show the inverse so stale values never match.
`timescale 1ns/1ps
module iacl_port_src
  import iacl_pkg::*;
(
  input  wire logic               sys_clk,
  output iacl_pkg::iacl_hdr_s     hdr,
  output logic                    hdr_valid,
  output logic                    l4_extra_ok
);
  initial begin
    hdr = '0;
    hdr_valid = 1'b0;
    l4_extra_ok = 1'b0;
  end
  task automatic send(input iacl_hdr_s h, input logic ok, input int gap);
    hdr_valid <= 1'b1;
    hdr <= h;
    l4_extra_ok <= ok;
    @(negedge sys_clk);
    if (gap > 0) begin
      hdr_valid <= 1'b0;
      hdr <= ~h;
      l4_extra_ok <= ~ok;
      // Let gap falling edges pass so the next call never re-drives the strobe at once.
      repeat (gap) @(negedge sys_clk);
    end
  endtask
endmodule

// ===== sim/tb.sv
// Purpose: Random entry and header sweep with a reference verdict.
// Assumes: Verdict pulses one cycle after each header.
// Notes:   Headers are biased toward the entry so hits occur.
`timescale 1ns/1ps
module tb;
  import iacl_pkg::*;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  iacl_cfg_s   cfg = '0;
  iacl_hdr_s   hdr;
  logic        hdr_valid, l4_extra_ok, hit_valid, hit, ipv4_sel;
  logic        exp_q[$];
  int          error_cnt = 0;
  int          checked = 0;
  logic [31:0] st = 32'd39142;
  always #20 sys_clk = ~sys_clk;
  iacl_matcher u_iacl_matcher (.sys_clk, .resetn, .cfg, .hdr_valid, .hdr,
    .l4_extra_ok, .hit_valid, .hit, .ipv4_sel);
  iacl_port_src u_iacl_port_src (.sys_clk, .hdr, .hdr_valid, .l4_extra_ok);
  function automatic logic [31:0] nx();
    st = st[0] ? (st >> 1) ^ 32'h80200003 : st >> 1;
    return st;
  endfunction
  function automatic logic tri_ok(iacl_tri_e m, logic v);
    return m == IACL_TRI_ANY || (m == IACL_TRI_NO && !v) ||
      (m == IACL_TRI_YES && v);
  endfunction
  function automatic logic ip_ok(iacl_ipflt_e m, logic [31:0] a, c, k);
    return m == IACL_IP_ANY || (m == IACL_IP_HOST && a == c) ||
      (m == IACL_IP_NETWORK && (a & k) == (c & k));
  endfunction
  function automatic logic ref_hit(iacl_cfg_s c, iacl_hdr_s h, logic ok);
    logic p;
    case (c.proto_mode)
      IACL_PR_ANY:      p = 1'b1;
      IACL_PR_SPECIFIC: p = h.proto == c.proto_value;
      IACL_PR_ICMP:     p = ok && h.proto == PROTO_ICMP;
      IACL_PR_UDP:      p = ok && h.proto == PROTO_UDP;
      IACL_PR_TCP:      p = ok && h.proto == PROTO_TCP;
      default:          p = 1'b0;
    endcase
    return c.frame_type == IACL_FT_IPV4 && h.is_ipv4 && p
      && tri_ok(c.ttl_mode, h.ttl != TTL_ZERO)
      && tri_ok(c.frag_mode, h.more_fragments_flag ||
         h.fragment_offset_field != FRAG_OFF_ZERO)
      && tri_ok(c.opt_mode, h.ihl > IHL_NO_OPT)
      && ip_ok(c.source_ip_filter, h.src_addr, c.src_addr,
         c.src_mask)
      && ip_ok(c.dest_ip_filter, h.dst_addr, c.dst_addr,
         c.dst_mask);
  endfunction
  task automatic chk(input string n, input logic e, input logic s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(negedge sys_clk) if (resetn && hit_valid !== 1'b0) begin
    chk("hit_valid", exp_q.size() > 0, hit_valid);
    if (exp_q.size() > 0) chk("hit", exp_q.pop_front(), hit);
    chk("ipv4_sel", cfg.frame_type == IACL_FT_IPV4, ipv4_sel);
  end
  initial begin
    logic [159:0] w;
    logic [127:0] v;
    iacl_cfg_s    c;
    iacl_hdr_s    h;
    repeat (4) @(negedge sys_clk);
    resetn = 1'b1;
    for (int i = 0; i < 600; i++) begin
      w = {nx(), nx(), nx(), nx(), nx()};
      v = {nx(), nx(), nx(), nx()};
      c = iacl_cfg_s'(w[148:0]);
      h = iacl_hdr_s'(v[98:0]);
      if (w[151]) c.frame_type = IACL_FT_IPV4;
      h.is_ipv4 = h.is_ipv4 | v[99];
      case (v[102:100])
        3'h0: h.proto = c.proto_value;
        3'h1: h.proto = PROTO_ICMP;
        3'h2: h.proto = PROTO_UDP;
        3'h3: h.proto = PROTO_TCP;
        default: ;
      endcase
      if (v[103]) h.ttl = TTL_ZERO;
      if (v[104]) h.fragment_offset_field = FRAG_OFF_ZERO;
      if (v[104]) h.more_fragments_flag = 1'b0;
      if (v[105]) h.ihl = IHL_NO_OPT;
      if (v[106]) h.src_addr = c.src_addr ^ (w[31:0] & ~c.src_mask);
      if (v[107]) h.dst_addr = c.dst_addr ^ (w[63:32] & ~c.dst_mask);
      exp_q.push_back(ref_hit(c, h, v[110]));
      cfg <= c;
      u_iacl_port_src.send(h, v[110],
        (i < 599 && v[113]) ? 0 : int'(v[112:111]) + 1);
    end
    repeat (3) @(negedge sys_clk);
    chk("queue_empty", 1'b1, exp_q.size() == 0);
    conclude();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    conclude();
  end
endmodule
